/* File: rtl/dpot_pkg.sv */
// Functional notes
// RQ1 - guard low blocks nonvolatile slot writes
// RQ2 - master starts transfers, drives clock alone
// RQ3 - data changes only while clock low
// RQ4 - start is data fall, clock high
// RQ5 - stop is data rise, clock high
// RQ6 - release after eight bits, receiver acks
// RQ7 - ack address, instruction, then data byte
// RQ8 - wiper decodes to exactly one tap
// RQ9 - wiper and slots readable, writable, transferable
// RQ10 - upper address nibble is device type
// RQ11 - lower address nibble matches strap pins
// RQ12 - stop after nonvolatile write starts busy
// RQ13 - no address ack while write busy
// RQ14 - master polls address until acknowledged
// RQ15 - instruction: opcode nibble, pot and slot
// RQ16 - slot bits, pot bit, zero bit (code: slot bits 3:2, zero bit 1, pot bit 0)
// RQ17 - step pulses move wiper up or down
// RQ18 - wipers load slot zero at power-up
// RQ19 - mismatch releases data, waits for start
package dpot_pkg;
  localparam int          CLK_MHZ      = 100;
  localparam int          NV_WRITE_US  = 5000;
  localparam int          NV_WRITE_CYC = NV_WRITE_US * CLK_MHZ;
  localparam int          HOST_QTR_NS  = 100;
  localparam int          HOST_QTR_CYC = HOST_QTR_NS * CLK_MHZ / 1000;
  localparam int          WIPER_W      = 6;
  localparam int          TAPS         = 64;
  localparam int          POTS         = 2;
  localparam int          SLOTS        = 4;
  localparam int          BYTE_BITS    = 8;
  // arbitrary value
  localparam logic [3:0]  DEV_TYPE_ID  = 4'ha;
  localparam logic [5:0]  SLOT_RST     = 6'h20;
  localparam int          ADDR_TYPE_LSB  = 4;
  localparam int          INSTR_OP_LSB   = 4;
  localparam int          INSTR_SLOT_LSB = 2;
  localparam int          INSTR_ZERO_BIT = 1;
  localparam int          INSTR_POT_BIT  = 0;
  localparam logic [3:0]  OP_RD_WIPER  = 4'h9;
  localparam logic [3:0]  OP_WR_WIPER  = 4'ha;
  localparam logic [3:0]  OP_RD_SLOT   = 4'hb;
  localparam logic [3:0]  OP_WR_SLOT   = 4'hc;
  localparam logic [3:0]  OP_XFR_S2W   = 4'hd;
  localparam logic [3:0]  OP_XFR_W2S   = 4'he;
  localparam logic [3:0]  OP_GXFR_S2W  = 4'h1;
  localparam logic [3:0]  OP_GXFR_W2S  = 4'h8;
  localparam logic [3:0]  OP_INCDEC    = 4'h2;
  localparam logic [3:0]  WB_CTRL      = 4'h0;
  localparam logic [3:0]  WB_TX        = 4'h4;
  localparam logic [3:0]  WB_STAT      = 4'h8;
  localparam int          CTRL_GO_BIT    = 0;
  localparam int          CTRL_NB_LSB    = 1;
  localparam int          CTRL_RD_BIT    = 3;
  localparam int          CTRL_STEPS_LSB = 8;
  localparam int          CTRL_DIR_BIT   = 12;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_NACK_BIT  = 1;
  localparam int          STAT_RX_LSB    = 8;
  typedef enum logic [2:0] {
    D_IDLE = 3'h0, D_ADDR = 3'h1, D_INSTR = 3'h3, D_DATA = 3'h2,
    D_READ = 3'h6, D_INCDEC = 3'h7, D_IGNORE = 3'h5
  } dpot_dev_st_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_START = 3'h1, H_BIT = 3'h3, H_STEP = 3'h2,
    H_STOP = 3'h6
  } dpot_host_st_t;
endpackage

/* File: rtl/dpot_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface dpot_link_if;
  logic scl;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic sda;
  // wired-and of both open-drain drivers
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);
  modport host (output scl, output sda_h_o, output sda_h_oe_n,
                input sda);
  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe_n);
endinterface
`default_nettype wire

/* File: rtl/dpot_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module dpot_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign lvl  = s2_r;
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
endmodule // dpot_sync
`default_nettype wire

/* File: rtl/dpot_dev.sv */
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module dpot_dev #(
  parameter int NV_CYC = dpot_pkg::NV_WRITE_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  dpot_link_if.dev                       link,
  input  wire logic [3:0]                strap_addr_pins,
  input  wire logic                      wp_n,
  output logic      [dpot_pkg::TAPS-1:0] tap_on_0,
  output logic      [dpot_pkg::TAPS-1:0] tap_on_1,
  output logic                           nv_busy
);
  import dpot_pkg::*;
  localparam int BW = $clog2(NV_CYC + 1);

  function automatic logic [TAPS-1:0] onehot(input logic [WIPER_W-1:0] w);
    logic [TAPS-1:0] v;
    v    = '0;
    v[w] = 1'b1;
    return v;
  endfunction

  logic [1:0]         pin_q;
  logic [1:0]         pin_rise;
  logic [1:0]         pin_fall;
  logic [4:0]         cfg_q;
  logic               start;
  logic               stop;
  dpot_dev_st_t       st_r, st_nxt;
  logic [3:0]         cnt_r, cnt_nxt;
  logic               ack_slot_r, ack_slot_nxt;
  logic [7:0]         sh_r, sh_nxt;
  logic [7:0]         tx_r, tx_nxt;
  logic [3:0]         op_r, op_nxt;
  logic               pot_r, pot_nxt;
  logic [1:0]         sel_r, sel_nxt;
  logic               oe_n_r, oe_n_nxt;
  logic               nv_pend_r, nv_pend_nxt;
  logic [WIPER_W-1:0] nv_dat_r, nv_dat_nxt;
  logic [BW-1:0]      busy_r, busy_nxt;
  logic               init_r;
  logic [WIPER_W-1:0] wiper_r [POTS];
  logic [WIPER_W-1:0] wiper_nxt [POTS];
  logic [WIPER_W-1:0] slots_r [POTS][SLOTS];
  logic [WIPER_W-1:0] slots_nxt [POTS][SLOTS];
  logic [TAPS-1:0]    tap0_nxt;
  logic [TAPS-1:0]    tap1_nxt;
  logic               ack;
  logic               ip;
  logic [1:0]         is;

  dpot_sync #(.W(2)) u_link_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({link.scl, link.sda}),
    .lvl  (pin_q),
    .rise (pin_rise),
    .fall (pin_fall)
  );
  dpot_sync #(.W(5)) u_strap_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({wp_n, strap_addr_pins}),
    .lvl  (cfg_q),
    .rise (),
    .fall ()
  );

  assign start = pin_fall[0] & pin_q[1]; // RQ4
  assign stop  = pin_rise[0] & pin_q[1]; // RQ5

  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    ack_slot_nxt = ack_slot_r;
    sh_nxt       = sh_r;
    tx_nxt       = tx_r;
    op_nxt       = op_r;
    pot_nxt      = pot_r;
    sel_nxt      = sel_r;
    oe_n_nxt     = oe_n_r;
    nv_pend_nxt  = nv_pend_r;
    nv_dat_nxt   = nv_dat_r;
    wiper_nxt    = wiper_r;
    slots_nxt    = slots_r;
    busy_nxt     = busy_r;
    ack          = 1'b0;
    ip           = sh_r[INSTR_POT_BIT];
    is           = sh_r[INSTR_SLOT_LSB +: 2];
    if (init_r) begin
      for (int p = 0; p < POTS; p++) begin
        wiper_nxt[p] = slots_r[p][0]; // RQ18
      end
    end
    if (busy_r != '0) begin
      busy_nxt = busy_r - 1'b1; // RQ12
    end
    if (start) begin
      st_nxt       = D_ADDR; // RQ4
      cnt_nxt      = '0;
      ack_slot_nxt = 1'b0;
      oe_n_nxt     = 1'b1;
      nv_pend_nxt  = 1'b0;
    end else if (stop) begin
      st_nxt       = D_IDLE; // RQ5
      ack_slot_nxt = 1'b0;
      oe_n_nxt     = 1'b1;
      nv_pend_nxt  = 1'b0;
      if (nv_pend_r && cfg_q[4]) begin // RQ1
        for (int p = 0; p < POTS; p++) begin
          if (op_r == OP_GXFR_W2S ||
              (op_r == OP_XFR_W2S && pot_r == 1'(p))) begin
            slots_nxt[p][sel_r] = wiper_r[p];
          end
        end
        if (op_r == OP_WR_SLOT) begin
          slots_nxt[pot_r][sel_r] = nv_dat_r;
        end
        busy_nxt = BW'(NV_CYC); // RQ12
      end
    end else if (pin_rise[1] && !ack_slot_r) begin
      if (st_r != D_INCDEC && cnt_r != 4'(BYTE_BITS)) begin
        sh_nxt  = {sh_r[6:0], pin_q[0]};
        tx_nxt  = {tx_r[6:0], 1'b0};
        cnt_nxt = cnt_r + 1'b1;
      end
    end else if (pin_fall[1] && st_r != D_IDLE) begin
      if (ack_slot_r) begin
        ack_slot_nxt = 1'b0; // RQ6
        cnt_nxt      = '0;
        oe_n_nxt     = (st_r == D_READ) ? tx_r[7] : 1'b1;
      end else if (st_r == D_READ) begin
        oe_n_nxt = (cnt_r == 4'(BYTE_BITS)) ? 1'b1 : tx_r[7]; // RQ3
        if (cnt_r == 4'(BYTE_BITS)) begin
          st_nxt = D_IGNORE; // RQ6
        end
      end else if (st_r == D_INCDEC) begin
        if (pin_q[0] && wiper_r[pot_r] != '1) begin
          wiper_nxt[pot_r] = wiper_r[pot_r] + 1'b1; // RQ17
        end else if (!pin_q[0] && wiper_r[pot_r] != '0) begin
          wiper_nxt[pot_r] = wiper_r[pot_r] - 1'b1; // RQ17
        end
      end else if (cnt_r == 4'(BYTE_BITS) &&
                   (st_r == D_ADDR || st_r == D_INSTR ||
                    st_r == D_DATA)) begin
        ack_slot_nxt = 1'b1;
        st_nxt       = D_IGNORE; // RQ19
        case (st_r)
          D_ADDR: begin
            if (sh_r[7:ADDR_TYPE_LSB] == DEV_TYPE_ID && // RQ10
                sh_r[ADDR_TYPE_LSB-1:0] == cfg_q[3:0] && // RQ11
                busy_r == '0) begin // RQ13
              ack    = 1'b1; // RQ7
              st_nxt = D_INSTR;
            end
          end
          D_INSTR: begin
            op_nxt  = sh_r[7:INSTR_OP_LSB]; // RQ15
            pot_nxt = ip; // RQ16
            sel_nxt = is; // RQ16
            if (!sh_r[INSTR_ZERO_BIT]) begin // RQ16
              ack = 1'b1; // RQ7
              case (sh_r[7:INSTR_OP_LSB])
                OP_RD_WIPER: begin
                  tx_nxt = {2'h0, wiper_r[ip]}; // RQ9
                  st_nxt = D_READ;
                end
                OP_RD_SLOT: begin
                  tx_nxt = {2'h0, slots_r[ip][is]}; // RQ9
                  st_nxt = D_READ;
                end
                OP_WR_WIPER, OP_WR_SLOT: st_nxt = D_DATA;
                OP_XFR_S2W: wiper_nxt[ip] = slots_r[ip][is]; // RQ9
                OP_GXFR_S2W: begin
                  for (int p = 0; p < POTS; p++) begin
                    wiper_nxt[p] = slots_r[p][is];
                  end
                end
                OP_XFR_W2S, OP_GXFR_W2S: nv_pend_nxt = 1'b1;
                OP_INCDEC: st_nxt = D_INCDEC;
                default: ack = 1'b0;
              endcase
            end
          end
          default: begin
            ack = 1'b1; // RQ7
            if (op_r == OP_WR_WIPER) begin
              wiper_nxt[pot_r] = sh_r[WIPER_W-1:0]; // RQ9
            end else begin
              nv_pend_nxt = 1'b1;
              nv_dat_nxt  = sh_r[WIPER_W-1:0];
            end
          end
        endcase
        oe_n_nxt = ~ack; // RQ6
      end
    end
    tap0_nxt = onehot(wiper_nxt[0]); // RQ8
    tap1_nxt = onehot(wiper_nxt[1]); // RQ8
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r       <= D_IDLE;
      cnt_r      <= '0;
      ack_slot_r <= 1'b0;
      sh_r       <= '0;
      tx_r       <= '0;
      op_r       <= '0;
      pot_r      <= 1'b0;
      sel_r      <= '0;
      oe_n_r     <= 1'b1;
      nv_pend_r  <= 1'b0;
      nv_dat_r   <= '0;
      busy_r     <= '0;
      init_r     <= 1'b1;
      wiper_r    <= '{default: SLOT_RST};
      slots_r    <= '{default: SLOT_RST};
      tap_on_0   <= onehot(SLOT_RST);
      tap_on_1   <= onehot(SLOT_RST);
      nv_busy    <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      ack_slot_r <= ack_slot_nxt;
      sh_r       <= sh_nxt;
      tx_r       <= tx_nxt;
      op_r       <= op_nxt;
      pot_r      <= pot_nxt;
      sel_r      <= sel_nxt;
      oe_n_r     <= oe_n_nxt;
      nv_pend_r  <= nv_pend_nxt;
      nv_dat_r   <= nv_dat_nxt;
      busy_r     <= busy_nxt;
      init_r     <= 1'b0;
      wiper_r    <= wiper_nxt;
      slots_r    <= slots_nxt;
      tap_on_0   <= tap0_nxt;
      tap_on_1   <= tap1_nxt;
      nv_busy    <= busy_nxt != '0;
    end
  end

  // never drives the clock, data is open drain only
  assign link.sda_d_o    = 1'b0; // RQ2
  assign link.sda_d_oe_n = oe_n_r;
endmodule // dpot_dev
`default_nettype wire

/* File: rtl/dpot_host.sv */
`timescale 1ns/100ps
`default_nettype none
module dpot_host (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [3:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_wdat,
  output logic      [31:0] wb_rdat,
  output logic             wb_ack,
  dpot_link_if.host        link
);
  import dpot_pkg::*;

  dpot_host_st_t st_r, st_nxt;
  logic [1:0]    ph_r, ph_nxt;
  logic [4:0]    div_r, div_nxt;
  logic [3:0]    bit_r, bit_nxt;
  logic [1:0]    byte_r, byte_nxt;
  logic [12:0]   ctrl_r, ctrl_nxt;
  logic [23:0]   txc_r, txc_nxt;
  logic [23:0]   tx_r, tx_nxt;
  logic [7:0]    sh_r, sh_nxt;
  logic [7:0]    rx_r, rx_nxt;
  logic [3:0]    steps_r, steps_nxt;
  logic          nack_r, nack_nxt;
  logic          scl_r, scl_nxt;
  logic          oe_n_r, oe_n_nxt;
  logic [31:0]   rdat_nxt;
  logic          ack_nxt;
  logic          sda_q;
  logic          req;
  logic          take;
  logic          busy;
  logic          tick;
  logic          last;
  logic          reading;

  dpot_sync #(.W(1)) u_sda_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (link.sda),
    .lvl  (sda_q),
    .rise (),
    .fall ()
  );

  assign req     = wb_cyc & wb_stb & ~wb_ack;
  assign take    = wb_cyc & wb_stb & wb_ack;
  assign busy    = st_r != H_IDLE;
  assign tick    = div_r == 5'(HOST_QTR_CYC - 1);
  assign last    = byte_r == 2'(ctrl_r[CTRL_NB_LSB +: 2] - 2'h1);
  assign reading = ctrl_r[CTRL_RD_BIT] & last & (byte_r != 2'h0);

  always_comb begin
    st_nxt    = st_r;
    ph_nxt    = ph_r;
    div_nxt   = busy ? (tick ? 5'h00 : div_r + 5'h01) : 5'h00;
    bit_nxt   = bit_r;
    byte_nxt  = byte_r;
    ctrl_nxt  = ctrl_r;
    txc_nxt   = txc_r;
    tx_nxt    = tx_r;
    sh_nxt    = sh_r;
    rx_nxt    = rx_r;
    steps_nxt = steps_r;
    nack_nxt  = nack_r;
    scl_nxt   = scl_r;
    oe_n_nxt  = oe_n_r;
    ack_nxt   = req;
    rdat_nxt  = wb_rdat;
    if (req) begin
      rdat_nxt = '0;
      case (wb_adr)
        WB_CTRL: rdat_nxt[12:0] = ctrl_r;
        WB_TX:   rdat_nxt[23:0] = txc_r;
        WB_STAT: begin
          rdat_nxt[STAT_BUSY_BIT]     = busy;
          rdat_nxt[STAT_NACK_BIT]     = nack_r;
          rdat_nxt[STAT_RX_LSB +: 8] = rx_r;
        end
        default: ;
      endcase
    end
    if (take) begin
      if (wb_we && wb_adr == WB_TX) begin
        for (int b = 0; b < 3; b++) begin
          if (wb_sel[b]) begin
            txc_nxt[b*8 +: 8] = wb_wdat[b*8 +: 8];
          end
        end
      end
      if (wb_we && wb_adr == WB_CTRL && !busy && wb_sel[1:0] == 2'h3) begin
        ctrl_nxt              = wb_wdat[12:0];
        ctrl_nxt[CTRL_GO_BIT] = 1'b0;
        if (wb_wdat[CTRL_GO_BIT] && wb_wdat[CTRL_NB_LSB +: 2] != 2'h0) begin
          st_nxt    = H_START; // RQ2
          ph_nxt    = 2'h0;
          nack_nxt  = 1'b0;
          tx_nxt    = {txc_nxt[7:0], txc_nxt[15:8], txc_nxt[23:16]};
          steps_nxt = wb_wdat[CTRL_STEPS_LSB +: 4];
        end
      end
    end
    if (busy && tick) begin
      ph_nxt = ph_r + 2'h1;
      case (st_r)
        H_START: begin
          if (ph_r == 2'h0) oe_n_nxt = 1'b0; // RQ4
          if (ph_r == 2'h3) begin
            scl_nxt  = 1'b0;
            st_nxt   = H_BIT;
            bit_nxt  = '0;
            byte_nxt = '0;
          end
        end
        H_BIT: begin
          case (ph_r)
            2'h0: oe_n_nxt = (bit_r == 4'(BYTE_BITS) || reading) ?
                             1'b1 : tx_r[23]; // RQ3
            2'h1: scl_nxt = 1'b1;
            2'h2: begin
              if (bit_r != 4'(BYTE_BITS)) sh_nxt = {sh_r[6:0], sda_q};
              else if (!reading) nack_nxt = sda_q; // RQ6
            end
            default: begin
              scl_nxt = 1'b0;
              if (bit_r != 4'(BYTE_BITS)) begin
                bit_nxt = bit_r + 4'h1;
                tx_nxt  = {tx_r[22:0], 1'b0};
              end else begin
                bit_nxt  = '0;
                byte_nxt = byte_r + 2'h1;
                if (reading) rx_nxt = sh_r;
                if (nack_r) st_nxt = H_STOP; // RQ14
                else if (last) st_nxt = (steps_r != '0) ? H_STEP : H_STOP;
              end
            end
          endcase
        end
        H_STEP: begin
          case (ph_r)
            2'h0: oe_n_nxt = ctrl_r[CTRL_DIR_BIT]; // RQ17
            2'h1: scl_nxt = 1'b1;
            2'h2: ;
            default: begin
              scl_nxt   = 1'b0;
              steps_nxt = steps_r - 4'h1;
              if (steps_r == 4'h1) st_nxt = H_STOP;
            end
          endcase
        end
        H_STOP: begin
          case (ph_r)
            2'h0: oe_n_nxt = 1'b0;
            2'h1: scl_nxt = 1'b1;
            2'h2: oe_n_nxt = 1'b1; // RQ5
            default: st_nxt = H_IDLE;
          endcase
        end
        default: st_nxt = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r    <= H_IDLE;
      ph_r    <= '0;
      div_r   <= '0;
      bit_r   <= '0;
      byte_r  <= '0;
      ctrl_r  <= '0;
      txc_r   <= '0;
      tx_r    <= '0;
      sh_r    <= '0;
      rx_r    <= '0;
      steps_r <= '0;
      nack_r  <= 1'b0;
      scl_r   <= 1'b1;
      oe_n_r  <= 1'b1;
      wb_rdat <= '0;
      wb_ack  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      ph_r    <= ph_nxt;
      div_r   <= div_nxt;
      bit_r   <= bit_nxt;
      byte_r  <= byte_nxt;
      ctrl_r  <= ctrl_nxt;
      txc_r   <= txc_nxt;
      tx_r    <= tx_nxt;
      sh_r    <= sh_nxt;
      rx_r    <= rx_nxt;
      steps_r <= steps_nxt;
      nack_r  <= nack_nxt;
      scl_r   <= scl_nxt;
      oe_n_r  <= oe_n_nxt;
      wb_rdat <= rdat_nxt;
      wb_ack  <= ack_nxt;
    end
  end

  assign link.scl        = scl_r; // RQ2
  assign link.sda_h_o    = 1'b0;
  assign link.sda_h_oe_n = oe_n_r;
endmodule // dpot_host
`default_nettype wire

/* File: testbench/dpot_link_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module dpot_link_properties #(
  parameter int NV_CYC = 200
) (
  input wire logic                      clk,
  input wire logic                      nrst,
  input wire logic                      scl,
  input wire logic                      sda,
  input wire logic                      sda_d_oe_n,
  input wire logic                      wp_n,
  input wire logic                      nv_busy,
  input wire logic [dpot_pkg::TAPS-1:0] tap_on_0,
  input wire logic [dpot_pkg::TAPS-1:0] tap_on_1
);
  import dpot_pkg::*;
  int bcnt_r;
  int bcnt_nxt;
  // busy length counter
  always_comb begin
    bcnt_nxt = nv_busy ? bcnt_r + 1 : 0;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bcnt_r <= 0;
    end else begin
      bcnt_r <= bcnt_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_tap0_one_hot: assert property ($onehot(tap_on_0))
    else $error("pot 0 tap select not one-hot");
  a_tap1_one_hot: assert property ($onehot(tap_on_1))
    else $error("pot 1 tap select not one-hot");
  a_dev_chg_low: assert property ($changed(sda_d_oe_n) |->
    !scl && !$past(scl) && !$past(scl, 2))
    else $error("device data changed near clock high");
  a_ack_hold: assert property ($rose(scl) && !sda_d_oe_n |->
    !sda_d_oe_n [*4])
    else $error("device drive not held through clock high");
  a_busy_quiet: assert property (nv_busy |-> sda_d_oe_n)
    else $error("device drove data while busy");
  a_busy_len: assert property ($fell(nv_busy) |->
    bcnt_r >= NV_CYC - 2 && bcnt_r <= NV_CYC + 2)
    else $error("write cycle length wrong");
  a_busy_guard: assert property ($rose(nv_busy) |-> $past(wp_n, 3))
    else $error("write cycle started with guard low");
  a_busy_after_stop: assert property ($rose(nv_busy) |->
    scl && sda && $past(scl && sda, 2))
    else $error("write cycle started without stop");
  a_start_quiet: assert property ($fell(sda) && scl |=>
    sda_d_oe_n [*8])
    else $error("device drove data right after start");
  a_stop_quiet: assert property ($rose(sda) && scl |=>
    sda_d_oe_n [*8])
    else $error("device drove data right after stop");
  c_busy: cover property ($rose(nv_busy));
  c_ack: cover property ($fell(sda_d_oe_n));
  c_start: cover property ($fell(sda) && scl);
endmodule // dpot_link_properties
`default_nettype wire

/* File: testbench/two_wire_dual_pot_slave_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module two_wire_dual_pot_slave_tb;
  import dpot_pkg::*;
  localparam int         NVC   = 2000;
  localparam logic [3:0] STRAP = 4'h6;
  localparam logic [7:0] ADR   = {DEV_TYPE_ID, STRAP};
  logic        clk       = 1'b0;
  logic        nrst      = 1'b0;
  logic        wb_cyc    = 1'b0;
  logic        wb_stb    = 1'b0;
  logic        wb_we     = 1'b0;
  logic [3:0]  wb_adr    = 4'h0;
  logic [3:0]  wb_sel    = 4'hf;
  logic [31:0] wb_wdat   = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [3:0]  straps    = STRAP;
  logic        wp_n      = 1'b1;
  logic [63:0] tap0;
  logic [63:0] tap1;
  logic        nv_busy;
  logic [31:0] st;
  int          n_errors  = 0;
  int          tests_run = 0;
  dpot_link_if dpot_link_if_i ();
  dpot_host dpot_host_i (.clk(clk), .nrst(nrst), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_wdat(wb_wdat), .wb_rdat(wb_rdat), .wb_ack(wb_ack),
    .link(dpot_link_if_i));
  dpot_dev #(.NV_CYC(NVC)) dpot_dev_i (.clk(clk), .nrst(nrst),
    .link(dpot_link_if_i), .strap_addr_pins(straps), .wp_n(wp_n),
    .tap_on_0(tap0), .tap_on_1(tap1), .nv_busy(nv_busy));
  dpot_link_properties #(.NV_CYC(NVC)) dpot_link_properties_i (
    .clk(clk), .nrst(nrst), .scl(dpot_link_if_i.scl),
    .sda(dpot_link_if_i.sda), .sda_d_oe_n(dpot_link_if_i.sda_d_oe_n),
    .wp_n(wp_n), .nv_busy(nv_busy), .tap_on_0(tap0), .tap_on_1(tap1));
  always #5 clk = ~clk;
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic give_up;
    n_errors++;
    final_report();
  endtask
  task automatic chk(input string nm, input logic [63:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    do begin
      @(negedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) give_up();
    q = wb_rdat;
    @(posedge clk);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  function automatic logic [31:0] cw(input logic [1:0] nb, input logic rd,
                                     input logic [3:0] s, input logic dir);
    cw = 32'h0;
    cw[CTRL_GO_BIT] = 1'b1;
    cw[CTRL_NB_LSB +: 2] = nb;
    cw[CTRL_RD_BIT] = rd;
    cw[CTRL_STEPS_LSB +: 4] = s;
    cw[CTRL_DIR_BIT] = dir;
  endfunction
  function automatic logic [7:0] ins(input logic [3:0] op,
                                     input logic [1:0] sl, input logic p);
    ins = {op, sl, 1'b0, p};
  endfunction
  function automatic logic [31:0] fr(input logic [7:0] a, i, d);
    fr = {8'h00, d, i, a};
  endfunction
  task automatic run(input logic [31:0] x, c);
    logic [31:0] q;
    int n;
    wb(1'b1, WB_TX, x, q);
    wb(1'b1, WB_CTRL, c, q);
    n = 0;
    do begin
      wb(1'b0, WB_STAT, 32'h0, st);
      n++;
    end while (st[STAT_BUSY_BIT] !== 1'b0 && n < 2000);
    if (st[STAT_BUSY_BIT] !== 1'b0) give_up();
  endtask
  task automatic wr(input logic [7:0] i, d);
    run(fr(ADR, i, d), cw(2'd3, 1'b0, 4'h0, 1'b0));
  endtask
  task automatic rd(input logic [7:0] i);
    run(fr(ADR, i, 8'h00), cw(2'd3, 1'b1, 4'h0, 1'b0));
  endtask
  task automatic nvw(input logic [7:0] i, d, input logic [1:0] nb);
    int n;
    run(fr(ADR, i, d), cw(nb, 1'b0, 4'h0, 1'b0));
    chk("busy", 64'(nv_busy), 64'h1);
    n = 0;
    do begin
      run(fr(ADR, 8'h00, 8'h00), cw(2'd1, 1'b0, 4'h0, 1'b0));
      if (n == 0) chk("poll", 64'(st[STAT_NACK_BIT]), 64'h1);
      n++;
    end while (st[STAT_NACK_BIT] !== 1'b0 && n < 50);
    if (st[STAT_NACK_BIT] !== 1'b0) give_up();
    chk("busy", 64'(nv_busy), 64'h0);
  endtask
  task automatic t_reset;
    logic [31:0] q;
    chk("tap0", tap0, 64'h1 << 32);
    chk("tap1", tap1, 64'h1 << 32);
    wb(1'b0, 4'hc, 32'h0, q);
    chk("unmapped", 64'(q), 64'h0);
  endtask
  task automatic t_wiper;
    wr(ins(OP_WR_WIPER, 2'd0, 1'b0), 8'h05);
    chk("nack", 64'(st[STAT_NACK_BIT]), 64'h0);
    chk("tap0", tap0, 64'h1 << 5);
    chk("tap1", tap1, 64'h1 << 32);
    wr(ins(OP_WR_WIPER, 2'd0, 1'b1), 8'hff);
    chk("tap1", tap1, 64'h1 << 63);
    rd(ins(OP_RD_WIPER, 2'd0, 1'b0));
    chk("rx", 64'(st[STAT_RX_LSB +: 8]), 64'h05);
  endtask
  task automatic t_step;
    run(fr(ADR, ins(OP_INCDEC, 2'd0, 1'b0), 8'h00),
        cw(2'd2, 1'b0, 4'h3, 1'b1));
    chk("tap0", tap0, 64'h1 << 8);
    run(fr(ADR, ins(OP_INCDEC, 2'd0, 1'b0), 8'h00),
        cw(2'd2, 1'b0, 4'h2, 1'b0));
    chk("tap0", tap0, 64'h1 << 6);
  endtask
  task automatic t_refuse;
    logic [31:0] bad [3];
    bad[0] = fr({~DEV_TYPE_ID, STRAP}, ins(OP_WR_WIPER, 2'd0, 1'b0), 8'h01);
    bad[1] = fr({DEV_TYPE_ID, STRAP ^ 4'h1}, ins(OP_WR_WIPER, 2'd0, 1'b0),
                8'h01);
    bad[2] = fr(ADR, ins(OP_WR_WIPER, 2'd0, 1'b0) | 8'h02, 8'h01);
    foreach (bad[k]) begin
      run(bad[k], cw(2'd3, 1'b0, 4'h0, 1'b0));
      chk("nack", 64'(st[STAT_NACK_BIT]), 64'h1);
      chk("tap0", tap0, 64'h1 << 6);
    end
  endtask
  task automatic t_guard;
    wp_n <= 1'b0;
    wr(ins(OP_WR_SLOT, 2'd1, 1'b0), 8'h11);
    chk("nack", 64'(st[STAT_NACK_BIT]), 64'h0);
    repeat (10) @(posedge clk);
    chk("busy", 64'(nv_busy), 64'h0);
    rd(ins(OP_RD_SLOT, 2'd1, 1'b0));
    chk("rx", 64'(st[STAT_RX_LSB +: 8]), 64'h20);
  endtask
  task automatic t_store;
    wp_n <= 1'b1;
    nvw(ins(OP_WR_SLOT, 2'd1, 1'b0), 8'h11, 2'd3);
    run(fr(ADR, ins(OP_XFR_S2W, 2'd1, 1'b0), 8'h00),
        cw(2'd2, 1'b0, 4'h0, 1'b0));
    chk("tap0", tap0, 64'h1 << 17);
    nvw(ins(OP_GXFR_W2S, 2'd3, 1'b0), 8'h00, 2'd2);
    nvw(ins(OP_XFR_W2S, 2'd2, 1'b1), 8'h00, 2'd2);
    wr(ins(OP_WR_WIPER, 2'd0, 1'b0), 8'h00);
    wr(ins(OP_WR_WIPER, 2'd0, 1'b1), 8'h00);
    run(fr(ADR, ins(OP_GXFR_S2W, 2'd3, 1'b0), 8'h00),
        cw(2'd2, 1'b0, 4'h0, 1'b0));
    chk("tap0", tap0, 64'h1 << 17);
    chk("tap1", tap1, 64'h1 << 63);
    rd(ins(OP_RD_SLOT, 2'd2, 1'b1));
    chk("rx", 64'(st[STAT_RX_LSB +: 8]), 64'h3f);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_wiper();
    t_step();
    t_refuse();
    t_guard();
    t_store();
    final_report();
  end
endmodule // two_wire_dual_pot_slave_tb
`default_nettype wire
